//--- sfr_defs.vh
// Constants for the servo fault supervision block
`ifndef SFR_DEFS_VH
`define SFR_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SFR_OFS_CTRL 8'h00
`define SFR_OFS_REACT 8'h04
`define SFR_OFS_TORQUE 8'h08
`define SFR_OFS_OSPD 8'h0c
`define SFR_OFS_OSPD2 8'h10
`define SFR_OFS_ALLOW 8'h14
`define SFR_OFS_STATUS 8'h18
`define SFR_OFS_IRQ_STAT 8'h1c
`define SFR_OFS_IRQ_MASK 8'h20
`define SFR_OFS_HIST_CNT 8'h24
`define SFR_OFS_HOLD_MAIN 8'h28
`define SFR_OFS_HIST0 8'h40
`define SFR_OFS_HIST7 8'h5c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFR_CTRL_RESET 0
`define SFR_IRQ_RAISE 0
`define SFR_IRQ_STOP 1
`define SFR_IRQ_TIMEOUT 2
`define SFR_IRQ_DONE 3
`define SFR_IRQ_ACCEPT 4
`define SFR_IRQ_REFUSE 5
`define SFR_IRQ_W 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFR_RST_REACT 8'h00
`define SFR_RST_TORQUE 16'h0000
`define SFR_RST_OSPD 16'hffff
`define SFR_RST_OSPD2 16'hffff
`define SFR_RST_ALLOW 16'h0000
`define SFR_RST_MASK 6'h00
`define SFR_RST_HOLD_MAIN 8'h00

// ----------------------------------------------------------------
// Fault codes and reaction range
// ----------------------------------------------------------------
`define SFR_MAIN_NET 8'h83
`define SFR_SUB_CSYNC 8'h03
`define SFR_MAIN_OSPD 8'h26
`define SFR_SUB_OSPD 8'h00
`define SFR_SUB_OSPD2 8'h01
`define SFR_MAIN_ABS_DOWN 8'h40
`define SFR_MAIN_ABS_OSPD 8'h42
`define SFR_CODE_MPU 16'hffff
`define SFR_REACT_LO 8'hf9
`define SFR_REACT_HI 8'hfc
`define SFR_STOP_RPM 16'h001e

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFR_CLK_HZ 200000000
`define SFR_HOLDOFF_S 10
`define SFR_HOLDOFF_CYC (`SFR_HOLDOFF_S * `SFR_CLK_HZ)
`define SFR_MS_PER_S 1000
`define SFR_MS_CYC (`SFR_CLK_HZ / `SFR_MS_PER_S)

`endif

//--- sfr_class.v
// Fault attribute decode from main and sub code
`include "sfr_defs.vh"

module sfr_class
(
    // Fault code
    input wire [7:0] i_main,
    input wire [7:0] i_sub,
    // Attributes
    output wire o_hist,
    output wire o_resettable,
    output wire o_master_dep,
    output wire o_no_usb,
    output wire o_abs_need,
    output wire o_imm_stop
);

    // ----------------------------------------------------------------
    // Attribute table
    // ----------------------------------------------------------------
    // Bits: hist, resettable, master_dep, no_usb, abs_need, imm_stop
    function [5:0] attr;
        input [7:0] m;
        input [7:0] s;
        begin
            case (m)
                `SFR_MAIN_NET:
                    if (s == `SFR_SUB_CSYNC)
                        attr = 6'h3c;
                    else if (s != 8'h00 && s < 8'h06)
                        attr = 6'h38;
                    else
                        attr = 6'h20;
                `SFR_MAIN_OSPD:
                    attr = (s == `SFR_SUB_OSPD) ? 6'h31 : 6'h30;
                8'h87: attr = 6'h10;
                8'h88: attr = 6'h20;
                8'h90: attr = 6'h38;
                8'h91: attr = 6'h30;
                8'h92: attr = 6'h20;
                8'h93: attr = 6'h20;
                8'h95: attr = 6'h00;
                8'h99: attr = 6'h00;
                `SFR_MAIN_ABS_DOWN: attr = 6'h12;
                `SFR_MAIN_ABS_OSPD: attr = 6'h32;
                default: attr = 6'h20;
            endcase
        end
    endfunction

    wire [5:0] a;
    assign a = attr(i_main, i_sub);
    assign o_hist = a[5];
    assign o_resettable = a[4];
    assign o_master_dep = a[3];
    assign o_no_usb = a[2];
    assign o_abs_need = a[1];
    assign o_imm_stop = a[0];

endmodule

//--- sfr_stop.v
// Immediate stop time supervision
`include "sfr_defs.vh"

module sfr_stop
#(
    parameter MS_CYC = `SFR_MS_CYC
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Control
    input wire i_run,
    input wire [15:0] i_allow_ms,
    input wire [15:0] i_speed,
    // Status
    output wire o_expired,
    output wire o_slow
);

    reg [31:0] pre_q;
    reg [15:0] ms_q;

    // ----------------------------------------------------------------
    // Millisecond count while stopping
    // ----------------------------------------------------------------
    // Restarts on each stop, so a stale count never shortens one
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pre_q <= 32'h0;
            ms_q <= 16'h0;
        end
        else if (!i_run)
        begin
            pre_q <= 32'h0;
            ms_q <= 16'h0;
        end
        else if (pre_q == MS_CYC - 1)
        begin
            pre_q <= 32'h0;
            if (ms_q != 16'hffff)
                ms_q <= ms_q + 16'h1;
        end
        else
            pre_q <= pre_q + 32'h1;
    end

    assign o_expired = i_run && (ms_q >= i_allow_ms);
    assign o_slow = i_speed < `SFR_STOP_RPM;

endmodule

//--- sfr_top.v
// Servo fault supervision, reset gating and immediate stop
//
// Behaviour
// - Faults named by main/sub; 83.1-83.5 network.
// - Master-dependent faults need cause removed first.
// - Fault 83.3 ignores USB reset requests.
// - Hold-off faults refuse reset for 10 s.
// - Absolute faults reset only after value cleared.
// - Non-resettable faults clear only by power cycle.
// - Resettable faults clear by fieldbus or tool.
// - Immediate stop only with reaction -4 to -7.
// - Speed above normal level raises 26.0.
// - During stop, speed above stop level raises 26.1.
// - Fault 26.1 never stops; trips at once.
// - 26.0 and 26.1 together trip directly.
// - Stop not below 30 r/min in time trips.
// - Non-stop fault during stop trips at once.
// - Torque limit output is the stop torque in every state.
// - Processor malfunction shows reserved display code.
// - History faults stored; others not stored.
`include "sfr_defs.vh"

module sfr_top
#(
    parameter HOLDOFF_CYC = `SFR_HOLDOFF_CYC,
    parameter MS_CYC = `SFR_MS_CYC
)
(
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    // Fault detection
    input wire i_fault_valid,
    input wire [7:0] i_fault_main,
    input wire [7:0] i_fault_sub,
    input wire [15:0] i_speed,
    input wire i_mpu_fault,
    // Reset requests and clearing conditions
    input wire i_rst_bus,
    input wire i_rst_tool,
    input wire i_rst_usb,
    input wire i_cause_cleared,
    input wire i_abs_cleared,
    // Drive reaction
    output wire o_stop_active,
    output wire [15:0] o_torque_lim,
    output wire o_tripped,
    output wire [15:0] o_disp_code,
    output wire o_irq
);

    localparam ST_RUN = 2'd0;
    localparam ST_STOP = 2'd1;
    localparam ST_TRIP = 2'd2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] react_q;
    reg [15:0] torque_q;
    reg [15:0] ospd_q;
    reg [15:0] ospd2_q;
    reg [15:0] allow_q;
    reg [7:0] hold_main_q;
    reg [5:0] irq_stat_q;
    reg [5:0] irq_mask_q;
    reg [15:0] code_q;
    reg [15:0] disp_q;
    reg hist_attr_q;
    reg rst_ok_q;
    reg mdep_q;
    reg no_usb_q;
    reg abs_need_q;
    reg hold_attr_q;
    reg abs_clr_q;
    reg [31:0] hold_cnt_q;
    reg ospd_prev_q;
    reg [31:0] rdata_q;
    reg [15:0] hist_mem [0:7];
    reg [2:0] hist_wp_q;
    reg [3:0] hist_cnt_q;
    reg [5:0] irq_set;
    reg [31:0] rd_d;
    reg evt_valid;
    reg [7:0] evt_main;
    reg [7:0] evt_sub;

    wire wr_en;
    wire rd_setup;
    wire addr_ok;
    wire ospd_now;
    wire ospd2_now;
    wire ospd_rise;
    wire ospd2_evt;
    wire c_hist;
    wire c_rst;
    wire c_mdep;
    wire c_nousb;
    wire c_abs;
    wire c_imm;
    wire react_ok;
    wire stop_expired;
    wire stop_slow;
    wire req_net;
    wire req_usb;
    wire req_any;
    wire rst_accept;
    wire raise;

    // ----------------------------------------------------------------
    // APB access
    // ----------------------------------------------------------------
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable;
    assign addr_ok = (i_paddr[1:0] == 2'b00) &&
        ((i_paddr <= `SFR_OFS_HOLD_MAIN) ||
         (i_paddr >= `SFR_OFS_HIST0 && i_paddr <= `SFR_OFS_HIST7));
    // Always ready; read data is taken in the setup cycle
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign o_prdata = rdata_q;

    always @*
    begin
        rd_d = 32'h0;
        case (i_paddr)
            `SFR_OFS_REACT: rd_d = {24'h0, react_q};
            `SFR_OFS_TORQUE: rd_d = {16'h0, torque_q};
            `SFR_OFS_OSPD: rd_d = {16'h0, ospd_q};
            `SFR_OFS_OSPD2: rd_d = {16'h0, ospd2_q};
            `SFR_OFS_ALLOW: rd_d = {16'h0, allow_q};
            `SFR_OFS_STATUS:
                rd_d = {12'h0, hold_cnt_q != 32'h0, i_mpu_fault,
                    state_q, code_q};
            `SFR_OFS_IRQ_STAT: rd_d = {26'h0, irq_stat_q};
            `SFR_OFS_IRQ_MASK: rd_d = {26'h0, irq_mask_q};
            `SFR_OFS_HIST_CNT: rd_d = {28'h0, hist_cnt_q};
            `SFR_OFS_HOLD_MAIN: rd_d = {24'h0, hold_main_q};
            default:
                if (i_paddr >= `SFR_OFS_HIST0 &&
                    i_paddr <= `SFR_OFS_HIST7)
                    rd_d = {16'h0, hist_mem[i_paddr[4:2]]};
                else
                    rd_d = 32'h0;
        endcase
    end

    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rdata_q <= 32'h0;
            react_q <= `SFR_RST_REACT;
            torque_q <= `SFR_RST_TORQUE;
            ospd_q <= `SFR_RST_OSPD;
            ospd2_q <= `SFR_RST_OSPD2;
            allow_q <= `SFR_RST_ALLOW;
            irq_mask_q <= `SFR_RST_MASK;
            hold_main_q <= `SFR_RST_HOLD_MAIN;
        end
        else
        begin
            if (rd_setup)
                rdata_q <= rd_d;
            if (wr_en)
            begin
                case (i_paddr)
                    `SFR_OFS_REACT: react_q <= i_pwdata[7:0];
                    `SFR_OFS_TORQUE: torque_q <= i_pwdata[15:0];
                    `SFR_OFS_OSPD: ospd_q <= i_pwdata[15:0];
                    `SFR_OFS_OSPD2: ospd2_q <= i_pwdata[15:0];
                    `SFR_OFS_ALLOW: allow_q <= i_pwdata[15:0];
                    `SFR_OFS_IRQ_MASK: irq_mask_q <= i_pwdata[5:0];
                    `SFR_OFS_HOLD_MAIN: hold_main_q <= i_pwdata[7:0];
                    default: rdata_q <= rdata_q;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Overspeed detection and event selection
    // ----------------------------------------------------------------
    assign ospd_now = i_speed > ospd_q;
    assign ospd2_now = i_speed > ospd2_q;
    assign ospd_rise = ospd_now && !ospd_prev_q;
    // Level 2 is watched in a stop, and also when level 1 first trips
    // so that a low level 2 setting skips the stop
    assign ospd2_evt = ospd2_now &&
        ((state_q == ST_STOP) || (state_q == ST_RUN && ospd_rise));

    always @*
    begin
        evt_valid = 1'b1;
        evt_main = `SFR_MAIN_OSPD;
        evt_sub = `SFR_SUB_OSPD;
        if (ospd2_evt)
            evt_sub = `SFR_SUB_OSPD2;
        else if (ospd_rise)
            evt_sub = `SFR_SUB_OSPD;
        else if (i_fault_valid)
        begin
            evt_main = i_fault_main;
            evt_sub = i_fault_sub;
        end
        else
            evt_valid = 1'b0;
    end

    sfr_class u_class
    (
        .i_main(evt_main),
        .i_sub(evt_sub),
        .o_hist(c_hist),
        .o_resettable(c_rst),
        .o_master_dep(c_mdep),
        .o_no_usb(c_nousb),
        .o_abs_need(c_abs),
        .o_imm_stop(c_imm)
    );

    // ----------------------------------------------------------------
    // Stop supervision
    // ----------------------------------------------------------------
    assign react_ok = ($signed(react_q) >= $signed(`SFR_REACT_LO)) &&
        ($signed(react_q) <= $signed(`SFR_REACT_HI));

    sfr_stop #(.MS_CYC(MS_CYC)) u_stop
    (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_run(state_q == ST_STOP),
        .i_allow_ms(allow_q),
        .i_speed(i_speed),
        .o_expired(stop_expired),
        .o_slow(stop_slow)
    );

    // ----------------------------------------------------------------
    // Reset request gating
    // ----------------------------------------------------------------
    assign req_net = i_rst_bus || i_rst_tool ||
        (wr_en && i_paddr == `SFR_OFS_CTRL && i_pwdata[`SFR_CTRL_RESET]);
    assign req_usb = i_rst_usb;
    assign req_any = (req_net || req_usb) && state_q == ST_TRIP;
    assign rst_accept = req_any &&
        rst_ok_q &&
        !(mdep_q && !i_cause_cleared) &&
        !(no_usb_q && !req_net) &&
        !(hold_attr_q && hold_cnt_q != 32'h0) &&
        !(abs_need_q && !abs_clr_q);
    assign raise = evt_valid && state_q == ST_RUN;

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        irq_set = 6'h00;
        case (state_q)
            ST_RUN:
                if (evt_valid)
                begin
                    irq_set[`SFR_IRQ_RAISE] = 1'b1;
                    if (c_imm && react_ok)
                    begin
                        state_d = ST_STOP;
                        irq_set[`SFR_IRQ_STOP] = 1'b1;
                    end
                    else
                        state_d = ST_TRIP;
                end
            ST_STOP:
                if (evt_valid && !c_imm)
                    state_d = ST_TRIP;
                else if (stop_slow)
                begin
                    state_d = ST_TRIP;
                    irq_set[`SFR_IRQ_DONE] = 1'b1;
                end
                else if (stop_expired)
                begin
                    state_d = ST_TRIP;
                    irq_set[`SFR_IRQ_TIMEOUT] = 1'b1;
                end
            ST_TRIP:
                if (rst_accept)
                begin
                    state_d = ST_RUN;
                    irq_set[`SFR_IRQ_ACCEPT] = 1'b1;
                end
                else if (req_any)
                    irq_set[`SFR_IRQ_REFUSE] = 1'b1;
            default: state_d = ST_RUN;
        endcase
    end

    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= ST_RUN;
            code_q <= 16'h0;
            hist_attr_q <= 1'b0;
            rst_ok_q <= 1'b0;
            mdep_q <= 1'b0;
            no_usb_q <= 1'b0;
            abs_need_q <= 1'b0;
            hold_attr_q <= 1'b0;
            abs_clr_q <= 1'b0;
            hold_cnt_q <= 32'h0;
            ospd_prev_q <= 1'b0;
            disp_q <= 16'h0;
        end
        else
        begin
            state_q <= state_d;
            ospd_prev_q <= ospd_now;
            // Only the first fault is latched; later history faults only go to history
            if (raise)
            begin
                code_q <= {evt_main, evt_sub};
                hist_attr_q <= c_hist;
                rst_ok_q <= c_rst;
                mdep_q <= c_mdep;
                no_usb_q <= c_nousb;
                abs_need_q <= c_abs;
                hold_attr_q <= (hold_main_q != 8'h00) &&
                    (evt_main == hold_main_q);
                hold_cnt_q <= HOLDOFF_CYC;
            end
            else if (hold_cnt_q != 32'h0)
                hold_cnt_q <= hold_cnt_q - 32'h1;
            if (raise)
                abs_clr_q <= 1'b0;
            else if (i_abs_cleared)
                abs_clr_q <= 1'b1;
            if (rst_accept)
                code_q <= 16'h0;
            // Display shows the reserved code over any fault number
            if (i_mpu_fault)
                disp_q <= `SFR_CODE_MPU;
            else if (raise)
                disp_q <= {evt_main, evt_sub};
            else if (rst_accept)
                disp_q <= 16'h0;
            else
                disp_q <= code_q;
        end
    end

    // ----------------------------------------------------------------
    // Fault history
    // ----------------------------------------------------------------
    // Eight entries, oldest overwritten once full
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            hist_wp_q <= 3'h0;
            hist_cnt_q <= 4'h0;
        end
        else if (evt_valid && c_hist)
        begin
            hist_wp_q <= hist_wp_q + 3'h1;
            if (hist_cnt_q != 4'h8)
                hist_cnt_q <= hist_cnt_q + 4'h1;
        end
    end

    always @(posedge i_clk)
    begin
        if (evt_valid && c_hist)
            hist_mem[hist_wp_q] <= {evt_main, evt_sub};
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // Set wins over a write-one clear in the same cycle
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            irq_stat_q <= 6'h00;
        else if (wr_en && i_paddr == `SFR_OFS_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~i_pwdata[5:0]) | irq_set;
        else
            irq_stat_q <= irq_stat_q | irq_set;
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_stop_active = state_q == ST_STOP;
    assign o_torque_lim = torque_q;
    assign o_tripped = state_q == ST_TRIP;
    assign o_disp_code = disp_q;

endmodule

//--- sfr_top_asserts.sv
// Port checker for the servo fault supervision block
// ----------
// Checker
// ----------
module sfr_top_asserts (
    input wire logic i_clk, i_rstn, i_psel, i_penable, i_fault_valid,
        i_mpu_fault, i_rst_bus, i_rst_tool, i_rst_usb, i_cause_cleared,
        o_pready, o_pslverr, o_stop_active, o_tripped,
    input wire logic [7:0] i_fault_main,
    input wire logic [15:0] i_speed,
    input wire logic [15:0] o_disp_code
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    wire any_rq = i_rst_bus | i_rst_tool | i_rst_usb;
    a_ready_high: assert property (o_pready)
        else $error("pready low");
    a_slverr_phase: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slverr phase");
    a_mpu_disp: assert property (i_mpu_fault [*2] |-> o_disp_code == 16'hffff)
        else $error("no mpu code");
    a_stop_end: assert property ($fell(o_stop_active) |-> o_tripped && $stable(o_disp_code))
        else $error("stop end");
    a_no_stop_2601: assert property ($rose(o_stop_active) |-> o_disp_code != 16'h2601)
        else $error("stop on 26.1");
    a_abort_stop: assert property (o_stop_active && i_fault_valid && i_fault_main == 8'h83 |=> o_tripped)
        else $error("no abort trip");
    a_slow_trip: assert property (o_stop_active && i_speed < 16'h001e |-> ##[1:2] o_tripped)
        else $error("no slow trip");
    a_usb_csync: assert property (o_tripped && o_disp_code == 16'h8303 && i_rst_usb && !i_rst_bus && !i_rst_tool |=> o_tripped)
        else $error("usb cleared");
    a_net_cause: assert property (o_tripped && o_disp_code[15:8] == 8'h83 && !i_cause_cleared && any_rq |=> o_tripped)
        else $error("cause ignored");
    a_fixed_fault: assert property (o_tripped && o_disp_code[15:8] == 8'h88 |=> o_tripped)
        else $error("latch cleared");
    a_tool_clear: assert property (o_tripped && o_disp_code == 16'h9101 && (i_rst_bus || i_rst_tool) |=> !o_tripped)
        else $error("not cleared");
    c_stop: cover property ($rose(o_stop_active));
    c_clear: cover property ($fell(o_tripped));
    c_slverr: cover property (o_pslverr);
    c_abort: cover property (o_stop_active && i_fault_valid);
endmodule
bind sfr_top sfr_top_asserts chk_u (.*);

//--- sfr_master_model.sv
// Fieldbus master and motor speed feedback model
// ----------
// Master
// ----------
module sfr_master_model (
    input wire logic i_clk,
    output logic o_rst_bus = 1'h0,
    output logic o_cause_cleared = 1'h0,
    output logic [15:0] o_speed = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    task spd(input logic [15:0] v);
        @(posedge i_clk);
        o_speed <= v;
    endtask
    task cause(input logic v);
        @(posedge i_clk);
        o_cause_cleared <= v;
    endtask
    task bus_reset;
        @(posedge i_clk);
        o_rst_bus <= 1'h1;
        @(posedge i_clk);
        o_rst_bus <= 1'h0;
    endtask
endmodule

//--- sfr_top_tb_top.sv
// Self-checking bench for the servo fault supervision block
`include "sfr_defs.vh"
module sfr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // Signals
    // ----------
    logic i_clk = 1'h0, i_rstn = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
    logic i_pwrite = 1'h0, i_fault_valid = 1'h0, i_mpu_fault = 1'h0;
    logic i_rst_tool = 1'h0, i_rst_usb = 1'h0, i_abs_cleared = 1'h0, serr;
    logic [7:0] i_paddr = 8'h00, i_fault_main = 8'h00, i_fault_sub = 8'h00;
    logic [31:0] i_pwdata = 32'h0, rd, seed = 32'hda5c, trq;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_stop_active, o_tripped, o_irq;
    wire i_rst_bus, i_cause_cleared;
    wire [15:0] o_torque_lim, o_disp_code, i_speed;
    int error_cnt = 0, cmp_count = 0;
    logic [7:0] rtab [7] = '{8'h00, 8'hf8, 8'hfd, 8'hf9, 8'hfa, 8'hfb, 8'hfc};
    logic [7:0] atab [6] = '{`SFR_OFS_REACT, `SFR_OFS_OSPD, `SFR_OFS_OSPD2,
        `SFR_OFS_ALLOW, `SFR_OFS_IRQ_MASK, 8'h30};
    logic [31:0] vtab [6] = '{32'h0, 32'hffff, 32'hffff, 32'h0, 32'h0, 32'h0};
    always #2.5 i_clk = ~i_clk;
    sfr_top #(.HOLDOFF_CYC(50), .MS_CYC(4)) dut_u (.*);
    sfr_master_model m_u (.i_clk, .o_rst_bus(i_rst_bus),
        .o_cause_cleared(i_cause_cleared), .o_speed(i_speed));
    // ----------
    // Tasks
    // ----------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task print_verdict;
        $display("cmp %0d err %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        do
        begin
            @(posedge i_clk);
            k++;
        end
        while (o_pready !== 1'h1 && k < 20);
        if (o_pready !== 1'h1)
        begin
            error_cnt++;
            print_verdict();
        end
        rd = o_prdata;
        serr = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        #1;
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task flt(input logic [15:0] c);
        @(posedge i_clk);
        i_fault_valid <= 1'h1;
        {i_fault_main, i_fault_sub} <= c;
        @(posedge i_clk);
        i_fault_valid <= 1'h0;
    endtask
    task req(input logic t, input logic u);
        @(posedge i_clk);
        i_rst_tool <= t;
        i_rst_usb <= u;
        @(posedge i_clk);
        i_rst_tool <= 1'h0;
        i_rst_usb <= 1'h0;
    endtask
    task trip(input string n, input logic e);
        repeat (3) @(posedge i_clk);
        chk(n, e, o_tripped);
    endtask
    task clr(input logic e = 1'h0);
        m_u.spd(16'h0064);
        m_u.bus_reset();
        trip("cleared", e);
    endtask
    initial
    begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        print_verdict();
    end
    // ----------
    // Scenarios
    // ----------
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'h1;
        foreach (atab[i])
            rchk("reset value", atab[i], vtab[i]);
        chk("unmapped error", 1'h1, serr);
        $display("test registers done");
        apb(1'h1, `SFR_OFS_OSPD, 32'd3000);
        apb(1'h1, `SFR_OFS_OSPD2, 32'd4000);
        apb(1'h1, `SFR_OFS_ALLOW, 32'h2);
        apb(1'h1, `SFR_OFS_IRQ_MASK, 32'h3f);
        trq = xs() & 32'hffff;
        apb(1'h1, `SFR_OFS_TORQUE, trq);
        m_u.spd(16'h0064);
        foreach (rtab[i])
        begin
            apb(1'h1, `SFR_OFS_REACT, {24'h0, rtab[i]});
            flt(16'h2600);
            repeat (2) @(posedge i_clk);
            chk("stop", rtab[i] >= 8'hf9 && rtab[i] <= 8'hfc, o_stop_active);
            if (o_stop_active === 1'h1)
                chk("torque", trq, o_torque_lim);
            m_u.spd(16'h000a);
            trip("slow stop", 1'h1);
            chk("code", 16'h2600, o_disp_code);
            clr();
        end
        $display("test reaction done");
        apb(1'h1, `SFR_OFS_IRQ_STAT, 32'h3f);
        flt(16'h2600);
        repeat (5) @(posedge i_clk);
        chk("early", 1'h0, o_tripped);
        repeat (6) @(posedge i_clk);
        chk("timeout", 1'h1, o_tripped);
        rchk("timeout flag", `SFR_OFS_IRQ_STAT, 32'h07);
        chk("irq on", 1'h1, o_irq);
        apb(1'h1, `SFR_OFS_IRQ_MASK, 32'h0);
        chk("irq masked", 1'h0, o_irq);
        apb(1'h1, `SFR_OFS_IRQ_MASK, 32'h3f);
        apb(1'h1, `SFR_OFS_IRQ_STAT, 32'h3f);
        chk("irq cleared", 1'h0, o_irq);
        clr();
        flt(16'h2600);
        flt(16'h8301);
        trip("abort", 1'h1);
        chk("abort code", 16'h2600, o_disp_code);
        clr();
        flt(16'h2600);
        m_u.spd(16'd4500);
        trip("overspeed in stop", 1'h1);
        clr();
        m_u.spd(16'd3001 + 16'(xs() % 999));
        repeat (3) @(posedge i_clk);
        chk("overspeed stop", 1'h1, o_stop_active);
        chk("overspeed code", 16'h2600, o_disp_code);
        m_u.spd(16'h000a);
        trip("overspeed slow", 1'h1);
        clr();
        m_u.spd(16'd4500);
        trip("double overspeed", 1'h1);
        chk("double code", 16'h2601, o_disp_code);
        clr();
        $display("test stop done");
        m_u.cause(1'h0);
        flt(16'h8303);
        req(1'h0, 1'h1);
        trip("usb refused", 1'h1);
        m_u.bus_reset();
        trip("cause refused", 1'h1);
        m_u.cause(1'h1);
        req(1'h0, 1'h1);
        trip("usb refused", 1'h1);
        req(1'h1, 1'h0);
        trip("tool accepted", 1'h0);
        m_u.cause(1'h0);
        flt(16'h8301);
        req(1'h0, 1'h1);
        trip("usb cause", 1'h1);
        m_u.cause(1'h1);
        req(1'h0, 1'h1);
        trip("usb accepted", 1'h0);
        apb(1'h1, `SFR_OFS_HOLD_MAIN, 32'h87);
        flt(16'h8700);
        clr(1'h1);
        chk("hold-off", 1'h1, o_tripped);
        repeat (50) @(posedge i_clk);
        clr();
        flt(16'h4000);
        clr(1'h1);
        chk("abs refused", 1'h1, o_tripped);
        @(posedge i_clk);
        i_abs_cleared <= 1'h1;
        @(posedge i_clk);
        i_abs_cleared <= 1'h0;
        clr();
        flt(16'h8801);
        req(1'h1, 1'h1);
        clr(1'h1);
        chk("latched", 1'h1, o_tripped);
        i_rstn <= 1'h0;
        @(posedge i_clk);
        i_rstn <= 1'h1;
        trip("power cycle", 1'h0);
        $display("test reset gating done");
        flt(16'h8700);
        rchk("no history", `SFR_OFS_HIST_CNT, 32'h0);
        clr();
        flt(16'h9101);
        rchk("history", `SFR_OFS_HIST_CNT, 32'h1);
        rchk("entry", `SFR_OFS_HIST0, 32'h9101);
        clr();
        i_mpu_fault <= 1'h1;
        repeat (3) @(posedge i_clk);
        chk("malfunction", 16'hffff, o_disp_code);
        $display("test history done");
        print_verdict();
    end
endmodule
